//--- hdl/twsl_top.sv
// two-wire slave receiver: wishbone registers and bus engine
//
// Contract
// - upper seven bits address, lsb enables general call
// - ack_enable low ignores own and general address
// - address plus write bit selects receiving
// - address match sets flag with valid status
// - lost arbitration then addressed reports 68/78
// - ack_enable cleared: next data byte not acknowledged
// - sleep keeps address recognition when ack enabled
// - sleep match wakes, holds clock until cleared
// - data register unreliable after sleep wake
// - own address write acknowledged reports 60
// - lost arbitration, own address acked reports 68
// - general call acknowledged reports 70
// - lost arbitration, general call acked reports 78
// - own-address data byte acked reports 80
// - flag cleared: receive byte, ack per enable
// - not-acked byte returns to not-addressed slave
// - stop or restart while addressed reports a0
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module twsl_top (
  input  wire logic        clk_i,      // 40 MHz system clock
  input  wire logic        rst_i,      // sync reset, high
  input  wire logic        wb_cyc_i,   // wishbone cycle
  input  wire logic        wb_stb_i,   // wishbone strobe
  input  wire logic        wb_we_i,    // wishbone write
  input  wire logic [4:0]  wb_adr_i,   // byte address
  input  wire logic [3:0]  wb_sel_i,   // byte enables
  input  wire logic [31:0] wb_dat_i,   // write data
  output logic      [31:0] wb_dat_o,   // read data
  output logic             wb_ack_o,   // acknowledge
  input  wire logic        scl_i,      // clock line level
  output logic             scl_o,      // clock line drive value
  output logic             scl_oe_o,   // clock line pulled low
  input  wire logic        sda_i,      // data line level
  output logic             sda_o,      // data line drive value
  output logic             sda_oe_o,   // data line pulled low
  input  wire logic        sleep_i,    // deep sleep, core asleep
  input  wire logic        arb_lost_i, // master lost arbitration
  output logic             wake_o,     // wake request
  output logic             start_go_o  // start may go, bus free
);
  logic [1:0]  pin_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_p;
  logic        stop_p;
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic [2:0]  widx;
  logic        req;
  logic        wr_go;
  logic        lo_lane;

  twsl_pkg::twsl_state_e st_r;
  twsl_pkg::twsl_state_e st_nxt;
  logic [3:0] cnt_r,    cnt_nxt;
  logic [7:0] sh_r,     sh_nxt;
  logic [7:0] own_r,    own_nxt;
  logic [7:0] data_r,   data_nxt;
  logic [7:0] stat_r,   stat_nxt;
  logic [1:0] presc_r,  presc_nxt;
  logic       flag_r,   flag_nxt;
  logic       ack_en_r, ack_en_nxt;
  logic       sta_r,    sta_nxt;
  logic       sto_r,    sto_nxt;
  logic       wc_r,     wc_nxt;
  logic       en_r,     en_nxt;
  logic       ie_r,     ie_nxt;
  logic       addr_r,   addr_nxt;
  logic       gc_r,     gc_nxt;
  logic       lost_r,   lost_nxt;
  logic       nak_r,    nak_nxt;
  logic       last_r,   last_nxt;
  logic       busy_r,   busy_nxt;
  logic       sdaoe_r,  sdaoe_nxt;
  logic       scloe_r,  scloe_nxt;
  logic       wake_r,   wake_nxt;
  logic       set_ev;
  logic       gc_hit;
  logic       own_hit;
  logic       hit;
  logic       byte_end;
  logic [7:0] ctrl_rd;

  // ==========================================================
  // pin synchronisers and condition detector
  twsl_sync #(.W(2), .STAGES(2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({scl_i, sda_i}),
    .q_o   (pin_s)
  );
  twsl_cond u_cond (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .scl_i   (pin_s[1]),
    .sda_i   (pin_s[0]),
    .rise_o  (scl_rise),
    .fall_o  (scl_fall),
    .start_o (start_p),
    .stop_o  (stop_p)
  );

  // ==========================================================
  // wishbone slave: ack one cycle after request, write on ack
  assign widx    = wb_adr_i[4:2];
  assign req     = wb_cyc_i & wb_stb_i;
  assign lo_lane = wb_sel_i[0];
  assign wr_go   = req & wb_we_i & ack_r & lo_lane;
  assign ctrl_rd = {flag_r, ack_en_r, sta_r, sto_r, wc_r, en_r, 1'b0, ie_r};

  always_comb begin
    ack_nxt  = req & ~ack_r;
    rdat_nxt = rdat_r;
    if (req && !ack_r) begin
      case (widx)
        twsl_pkg::IDX_ADDR: rdat_nxt = {24'h0, own_r};
        twsl_pkg::IDX_CTRL: rdat_nxt = {24'h0, ctrl_rd};
        twsl_pkg::IDX_STAT: rdat_nxt = {24'h0, stat_r[7:3], 1'b0, presc_r};
        twsl_pkg::IDX_DATA: rdat_nxt = {24'h0, data_r};
        default:            rdat_nxt = 32'h0;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      ack_r  <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ==========================================================
  // address match
  assign gc_hit   = sh_r[7:1] == twsl_pkg::GC_ADDR;
  assign own_hit  = (sh_r[7:1] == own_r[7:1]) & ~gc_hit;
  // only the write direction is served here; reads are not acked
  assign hit      = en_r & ack_en_r & ~sh_r[0]
                  & (own_hit | (gc_hit & own_r[twsl_pkg::B_GCE]));
  assign byte_end = scl_fall & (cnt_r == twsl_pkg::BITS_BYTE);

  // ==========================================================
  // register and bus engine
  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    sh_nxt     = sh_r;
    own_nxt    = own_r;
    data_nxt   = data_r;
    stat_nxt   = stat_r;
    presc_nxt  = presc_r;
    flag_nxt   = flag_r;
    ack_en_nxt = ack_en_r;
    sta_nxt    = sta_r;
    sto_nxt    = sto_r;
    wc_nxt     = wc_r;
    en_nxt     = en_r;
    ie_nxt     = ie_r;
    addr_nxt   = addr_r;
    gc_nxt     = gc_r;
    lost_nxt   = lost_r;
    nak_nxt    = nak_r;
    last_nxt   = last_r;
    busy_nxt   = busy_r;
    sdaoe_nxt  = sdaoe_r;
    set_ev     = 1'b0;
    // software side
    if (wr_go && widx == twsl_pkg::IDX_ADDR) begin
      own_nxt = wb_dat_i[7:0];
    end
    if (wr_go && widx == twsl_pkg::IDX_CTRL) begin
      ack_en_nxt = wb_dat_i[twsl_pkg::B_EA];
      sta_nxt    = wb_dat_i[twsl_pkg::B_STA];
      sto_nxt    = wb_dat_i[twsl_pkg::B_STO];
      en_nxt     = wb_dat_i[twsl_pkg::B_EN];
      ie_nxt     = wb_dat_i[twsl_pkg::B_IE];
      if (wb_dat_i[twsl_pkg::B_INT]) begin
        flag_nxt = 1'b0;
      end
    end
    if (wr_go && widx == twsl_pkg::IDX_STAT) begin
      presc_nxt = wb_dat_i[1:0];
    end
    if (wr_go && widx == twsl_pkg::IDX_DATA) begin
      if (flag_r) begin
        data_nxt = wb_dat_i[7:0];
        wc_nxt   = 1'b0;
      end else begin
        wc_nxt = 1'b1;
      end
    end
    if (arb_lost_i) begin
      lost_nxt = 1'b1;
    end
    if (start_p) begin
      busy_nxt = 1'b1;
    end
    if (stop_p) begin
      busy_nxt = 1'b0;
    end
    // bus side; the clock is sampled, so deep sleep keeps working
    case (st_r)
      twsl_pkg::ST_IDLE: begin
      end
      twsl_pkg::ST_ADDR: begin
        if (scl_rise) begin
          sh_nxt  = {sh_r[6:0], pin_s[0]};
          cnt_nxt = cnt_r + 4'h1;
        end else if (byte_end) begin
          gc_nxt = gc_hit;
          if (hit) begin
            st_nxt    = twsl_pkg::ST_AACK;
            sdaoe_nxt = 1'b1;
          end else begin
            st_nxt   = twsl_pkg::ST_IDLE;
            lost_nxt = 1'b0;
          end
        end
      end
      twsl_pkg::ST_AACK: begin
        if (scl_fall) begin
          sdaoe_nxt = 1'b0;
          addr_nxt  = 1'b1;
          set_ev    = 1'b1;
          last_nxt  = 1'b0;
          lost_nxt  = 1'b0;
          st_nxt    = twsl_pkg::ST_HOLD;
          if (gc_r) begin
            stat_nxt = lost_r ? twsl_pkg::STS_LOST_GC
                              : twsl_pkg::STS_GC;
          end else begin
            stat_nxt = lost_r ? twsl_pkg::STS_LOST_OWN
                              : twsl_pkg::STS_OWN;
          end
        end
      end
      twsl_pkg::ST_HOLD: begin
        if (!flag_r) begin
          st_nxt  = last_r ? twsl_pkg::ST_IDLE : twsl_pkg::ST_DATA;
          cnt_nxt = 4'h0;
        end
      end
      twsl_pkg::ST_DATA: begin
        if (scl_rise) begin
          sh_nxt  = {sh_r[6:0], pin_s[0]};
          cnt_nxt = cnt_r + 4'h1;
        end else if (byte_end) begin
          nak_nxt   = ~ack_en_r;
          sdaoe_nxt = ack_en_r;
          // the sleeping core does not take the byte
          if (!sleep_i) begin
            data_nxt = sh_r;
          end
          st_nxt = twsl_pkg::ST_DACK;
        end
      end
      twsl_pkg::ST_DACK: begin
        if (scl_fall) begin
          sdaoe_nxt = 1'b0;
          set_ev    = 1'b1;
          last_nxt  = nak_r;
          st_nxt    = twsl_pkg::ST_HOLD;
          if (gc_r) begin
            stat_nxt = nak_r ? twsl_pkg::STS_GCD_NAK : twsl_pkg::STS_GCD_ACK;
          end else begin
            stat_nxt = nak_r ? twsl_pkg::STS_DAT_NAK
                             : twsl_pkg::STS_DAT_ACK;
          end
          if (nak_r) begin
            addr_nxt = 1'b0;
          end
        end
      end
      default: begin
        st_nxt = twsl_pkg::ST_IDLE;
      end
    endcase
    if (start_p || stop_p) begin
      if (addr_r) begin
        set_ev   = 1'b1;
        stat_nxt = twsl_pkg::STS_STOP;
        addr_nxt = 1'b0;
      end
      sdaoe_nxt = 1'b0;
      cnt_nxt   = 4'h0;
      st_nxt    = start_p ? twsl_pkg::ST_ADDR : twsl_pkg::ST_IDLE;
    end
    if (!en_r) begin
      st_nxt    = twsl_pkg::ST_IDLE;
      sdaoe_nxt = 1'b0;
      addr_nxt  = 1'b0;
    end
    // a hardware event beats a clear written in the same cycle
    if (set_ev) begin
      flag_nxt = 1'b1;
    end
    scloe_nxt = (st_nxt == twsl_pkg::ST_HOLD) & flag_nxt;
    wake_nxt  = sleep_i & flag_nxt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r     <= twsl_pkg::ST_IDLE;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      own_r    <= twsl_pkg::ADDR_RST;
      data_r   <= twsl_pkg::DATA_RST;
      stat_r   <= twsl_pkg::STS_IDLE;
      presc_r  <= twsl_pkg::PRESC_RST;
      flag_r   <= 1'b0;
      ack_en_r <= 1'b0;
      sta_r    <= 1'b0;
      sto_r    <= 1'b0;
      wc_r     <= 1'b0;
      en_r     <= 1'b0;
      ie_r     <= 1'b0;
      addr_r   <= 1'b0;
      gc_r     <= 1'b0;
      lost_r   <= 1'b0;
      nak_r    <= 1'b0;
      last_r   <= 1'b0;
      busy_r   <= 1'b0;
      sdaoe_r  <= 1'b0;
      scloe_r  <= 1'b0;
      wake_r   <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      sh_r     <= sh_nxt;
      own_r    <= own_nxt;
      data_r   <= data_nxt;
      stat_r   <= stat_nxt;
      presc_r  <= presc_nxt;
      flag_r   <= flag_nxt;
      ack_en_r <= ack_en_nxt;
      sta_r    <= sta_nxt;
      sto_r    <= sto_nxt;
      wc_r     <= wc_nxt;
      en_r     <= en_nxt;
      ie_r     <= ie_nxt;
      addr_r   <= addr_nxt;
      gc_r     <= gc_nxt;
      lost_r   <= lost_nxt;
      nak_r    <= nak_nxt;
      last_r   <= last_nxt;
      busy_r   <= busy_nxt;
      sdaoe_r  <= sdaoe_nxt;
      scloe_r  <= scloe_nxt;
      wake_r   <= wake_nxt;
    end
  end

  // open-drain: only ever pull low
  assign scl_o      = 1'b0;
  assign sda_o      = 1'b0;
  assign scl_oe_o   = scloe_r;
  assign sda_oe_o   = sdaoe_r;
  assign wake_o     = wake_r;
  // master side waits for a free bus before its start
  assign start_go_o = en_r & sta_r & ~busy_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  no_ack_dis_a: assert property (
    (st_r == twsl_pkg::ST_ADDR && byte_end && !ack_en_r && !start_p && !stop_p)
      |=> !sda_oe_o && st_r == twsl_pkg::ST_IDLE)
    else $error("address acked with ack_enable low");
  gc_ignore_a: assert property (
    (st_r == twsl_pkg::ST_ADDR && byte_end && gc_hit && !own_r[twsl_pkg::B_GCE])
      |=> !sda_oe_o)
    else $error("general call acked while disabled");
  own_sts_a: assert property (
    (st_r == twsl_pkg::ST_AACK && scl_fall && !gc_r && !lost_r && en_r
     && !start_p && !stop_p)
      |=> flag_r && stat_r == twsl_pkg::STS_OWN && scl_oe_o)
    else $error("own address did not report 60");
  lost_own_a: assert property (
    (st_r == twsl_pkg::ST_AACK && scl_fall && !gc_r && lost_r && en_r
     && !start_p && !stop_p)
      |=> stat_r == twsl_pkg::STS_LOST_OWN)
    else $error("lost arbitration did not report 68");
  gc_sts_a: assert property (
    (st_r == twsl_pkg::ST_AACK && scl_fall && gc_r && !lost_r && en_r
     && !start_p && !stop_p)
      |=> stat_r == twsl_pkg::STS_GC)
    else $error("general call did not report 70");
  data_sts_a: assert property (
    (st_r == twsl_pkg::ST_DACK && scl_fall && !nak_r && !gc_r && en_r
     && !start_p && !stop_p)
      |=> stat_r == twsl_pkg::STS_DAT_ACK && flag_r)
    else $error("acked data did not report 80");
  nak_byte_a: assert property (
    (st_r == twsl_pkg::ST_DATA && byte_end && !ack_en_r && en_r && !start_p && !stop_p)
      |=> !sda_oe_o [*2])
    else $error("data line pulled after ack_enable cleared");
  stop_sts_a: assert property (
    (stop_p && addr_r) |=> stat_r == twsl_pkg::STS_STOP && !addr_r && flag_r)
    else $error("stop while addressed not reported");
  stretch_a: assert property (
    (flag_r && addr_r) |-> scl_oe_o)
    else $error("clock not held while flag set");
  nak_leave_a: assert property (
    (st_r == twsl_pkg::ST_HOLD && last_r && !flag_r && !start_p && !stop_p)
      |=> st_r == twsl_pkg::ST_IDLE && !addr_r)
    else $error("not-addressed mode not entered after nack");
  wake_hold_a: assert property (
    (sleep_i && flag_r && st_r == twsl_pkg::ST_HOLD && en_r && !start_p && !stop_p
     && !(wr_go && widx == twsl_pkg::IDX_CTRL && wb_dat_i[twsl_pkg::B_INT]))
      |=> wake_o && scl_oe_o)
    else $error("wake or hold missing in sleep");
  flag_wins_a: assert property (
    (set_ev && wr_go && widx == twsl_pkg::IDX_CTRL) |=> flag_r)
    else $error("flag set lost to a clear");

  own_rx_c:  cover property (st_r == twsl_pkg::ST_DACK && scl_fall && !nak_r);
  gc_rx_c:   cover property (st_r == twsl_pkg::ST_AACK && scl_fall && gc_r);
  nak_rx_c:  cover property (st_r == twsl_pkg::ST_DACK && scl_fall && nak_r);
  sleep_c:   cover property (sleep_i && wake_o);
endmodule : twsl_top
`default_nettype wire

//--- inc/twsl_pkg.sv
// shared constants and types of the two-wire slave receiver
package twsl_pkg;
  // ==========================================================
  // register map: word index, byte address is index * 4
  localparam logic [2:0] IDX_ADDR = 3'h0;
  localparam logic [2:0] IDX_CTRL = 3'h1;
  localparam logic [2:0] IDX_STAT = 3'h2;
  localparam logic [2:0] IDX_DATA = 3'h3;
  // ==========================================================
  // bus_control bit positions
  localparam int B_INT = 7;
  localparam int B_EA  = 6;
  localparam int B_STA = 5;
  localparam int B_STO = 4;
  localparam int B_WC  = 3;
  localparam int B_EN  = 2;
  localparam int B_IE  = 0;
  // general_call_enable in own_slave_address
  localparam int B_GCE = 0;
  // ==========================================================
  // reset values
  localparam logic [7:0] ADDR_RST  = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'hff;
  localparam logic [1:0] PRESC_RST = 2'h0;
  // ==========================================================
  // status codes, prescaler bits zero
  localparam logic [7:0] STS_OWN     = 8'h60;
  localparam logic [7:0] STS_LOST_OWN = 8'h68;
  localparam logic [7:0] STS_GC      = 8'h70;
  localparam logic [7:0] STS_LOST_GC = 8'h78;
  localparam logic [7:0] STS_DAT_ACK = 8'h80;
  localparam logic [7:0] STS_DAT_NAK = 8'h88;
  localparam logic [7:0] STS_GCD_ACK = 8'h90;
  localparam logic [7:0] STS_GCD_NAK = 8'h98;
  localparam logic [7:0] STS_STOP    = 8'ha0;
  localparam logic [7:0] STS_IDLE    = 8'hf8;
  // ==========================================================
  // bus constants
  localparam logic [6:0] GC_ADDR   = 7'h00;
  localparam logic [3:0] BITS_BYTE = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_HOLD,
    ST_DATA,
    ST_DACK
  } twsl_state_e;
endpackage : twsl_pkg

//--- hdl/twsl_sync.sv
// two-flop synchronisers for the bus pins
`timescale 1ns/10ps
`default_nettype none
module twsl_sync #(
  parameter int W      = 2,
  parameter int STAGES = 2
) (
  input  wire logic         clk_i, // system clock
  input  wire logic         rst_i, // sync reset, high
  input  wire logic [W-1:0] d_i,   // asynchronous pins
  output logic      [W-1:0] q_o    // synchronised copy
);
  if (STAGES < 2) begin : g_chk
    $error("twsl_sync needs at least two stages");
  end
  // ==========================================================
  // one chain per pin; idle bus level is high
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic [STAGES-1:0] ch_r;
    logic [STAGES-1:0] ch_nxt;
    always_comb begin
      ch_nxt = {ch_r[STAGES-2:0], d_i[i]};
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ch_r <= '1;
      end else begin
        ch_r <= ch_nxt;
      end
    end
    assign q_o[i] = ch_r[STAGES-1];
  end
endmodule : twsl_sync
`default_nettype wire

//--- hdl/twsl_cond.sv
// edge and start/stop condition detector on synchronised pins
`timescale 1ns/10ps
`default_nettype none
module twsl_cond (
  input  wire logic clk_i,    // system clock
  input  wire logic rst_i,    // sync reset, high
  input  wire logic scl_i,    // synchronised clock line
  input  wire logic sda_i,    // synchronised data line
  output logic      rise_o,   // clock line rose
  output logic      fall_o,   // clock line fell
  output logic      start_o,  // start or repeated start
  output logic      stop_o    // stop condition
);
  logic scl_r;
  logic sda_r;
  logic scl_nxt;
  logic sda_nxt;
  // ==========================================================
  always_comb begin
    scl_nxt = scl_i;
    sda_nxt = sda_i;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
    end
  end
  assign rise_o  = scl_i & ~scl_r;
  assign fall_o  = ~scl_i & scl_r;
  // data moving while the clock stays high marks a condition
  assign start_o = scl_i & scl_r & sda_r & ~sda_i;
  assign stop_o  = scl_i & scl_r & ~sda_r & sda_i;
endmodule : twsl_cond
`default_nettype wire

//--- sim/twsl_mst_model.sv
// behavioural two-wire bus master transmitter on open-drain lines
`timescale 1ns/10ps
`default_nettype none
module twsl_mst_model (
  input  wire logic scl_i,     // resolved clock line
  input  wire logic sda_i,     // resolved data line
  output logic      scl_low_o, // pull clock line low
  output logic      sda_low_o  // pull data line low
);
  int hangs = 0;
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // ==========================================
  // bit timing
  // a slave may stretch the low phase, so every rise is awaited
  task automatic wait_hi;
    int n;
    n = 0;
    while (scl_i !== 1'b1 && n < 5000) begin
      #10;
      n++;
    end
    if (scl_i !== 1'b1) hangs++;
  endtask : wait_hi
  // data changes late in the low phase, well after the slave lets go of its ack
  task automatic clk_bit(input logic b, output logic s);
    #110;
    sda_low_o = ~b;
    #20;
    scl_low_o = 1'b0;
    wait_hi();
    #60;
    s = sda_i;
    #10;
    scl_low_o = 1'b1;
  endtask : clk_bit
  // ==========================================
  // frame pieces
  task automatic start_c;
    #13;
    sda_low_o = 1'b1;
    #100;
    scl_low_o = 1'b1;
  endtask : start_c
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
    #100;
  endtask : put_byte
  task automatic stop_c;
    #110;
    sda_low_o = 1'b1;
    #20;
    scl_low_o = 1'b0;
    wait_hi();
    #70;
    sda_low_o = 1'b0;
    #100;
  endtask : stop_c
endmodule : twsl_mst_model
`default_nettype wire

//--- sim/test_two_wire_slave_receiver.sv
// self-checking bench of the two-wire slave receiver
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module test_two_wire_slave_receiver;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        scl_o, scl_oe_o, sda_o, sda_oe_o, wake_o;
  logic        sleep_i = 1'b0;
  logic        arb_lost_i = 1'b0;
  logic        m_scl, m_sda, ack, go;
  logic [7:0]  own, ctl, byt, flg, sts;
  int          miscompares = 0;
  int          n_tests = 0;
  wire         scl_w = (scl_oe_o ? scl_o : 1'b1) & ~m_scl;
  wire         sda_w = (sda_oe_o ? sda_o : 1'b1) & ~m_sda;
  // own, control, address byte, {arb, ack}, status
  localparam logic [39:0] CASES [8] = '{40'ha9_44_a8_01_60, 40'ha9_44_00_01_70,
    40'ha9_44_a8_11_68, 40'ha9_44_00_11_78, 40'ha9_04_a8_00_00,
    40'ha8_44_00_00_00, 40'ha9_44_a9_00_00, 40'ha9_44_aa_00_00};
  always #12.5 clk_i = ~clk_i;
  twsl_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .sleep_i(sleep_i), .arb_lost_i(arb_lost_i),
    .wake_o(wake_o), .start_go_o(go));
  twsl_mst_model mst_u (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl), .sda_low_o(m_sda));
  // ==========================================
  // register access
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic wb_xfer(input logic w, input logic [4:0] a, input logic [7:0] d,
                         output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      end_of_test();
    end else begin
      r = wb_dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask : wb_xfer
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb_xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rdchk(input string nm, input logic [4:0] a, input logic [7:0] m,
                       input logic [7:0] e);
    logic [7:0] r;
    wb_xfer(1'b0, a, 8'h00, r);
    `CHK(nm, e, r & m)
  endtask : rdchk
  // ==========================================
  // scenarios
  initial begin
    #1000000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("own reset", 5'h00, 8'hff, 8'h00);
    rdchk("control reset", 5'h04, 8'hff, 8'h00);
    rdchk("status reset", 5'h08, 8'hff, 8'hf8);
    rdchk("data reset", 5'h0c, 8'hff, 8'hff);
    rdchk("unmapped", 5'h10, 8'hff, 8'h00);
    wr(5'h08, 8'h03);
    rdchk("prescaler", 5'h08, 8'h07, 8'h03);
    for (int i = 0; i < 8; i++) begin
      {own, ctl, byt, flg, sts} = CASES[i];
      wr(5'h00, own);
      wr(5'h04, ctl);
      if (flg[4]) begin
        @(posedge clk_i);
        arb_lost_i <= 1'b1;
        @(posedge clk_i);
        arb_lost_i <= 1'b0;
      end
      mst_u.start_c();
      mst_u.put_byte(byt, ack);
      `CHK("address ack", flg[0], ack)
      if (flg[0]) begin
        rdchk("flag", 5'h04, 8'h80, 8'h80);
        rdchk("status", 5'h08, 8'hf8, sts);
        `CHK("stretch", 1'b1, scl_oe_o)
        wr(5'h04, 8'hc4);
        repeat (2) @(posedge clk_i);
        `CHK("released", 1'b0, scl_oe_o)
        if (byt == 8'h00) begin
          mst_u.put_byte(8'h5a, ack);
          `CHK("gc data ack", 1'b1, ack)
          rdchk("gc data status", 5'h08, 8'hf8, 8'h90);
          wr(5'h04, 8'hc4);
        end
      end
      mst_u.stop_c();
      if (flg[0]) begin
        rdchk("stop status", 5'h08, 8'hf8, 8'ha0);
        wr(5'h04, 8'hc4);
      end
    end
    wr(5'h00, 8'ha9);
    mst_u.start_c();
    mst_u.put_byte(8'ha8, ack);
    wr(5'h04, 8'hc4);
    mst_u.put_byte(8'h3c, ack);
    `CHK("data ack", 1'b1, ack)
    rdchk("data status", 5'h08, 8'hf8, 8'h80);
    rdchk("data byte", 5'h0c, 8'hff, 8'h3c);
    wr(5'h04, 8'h84);
    mst_u.put_byte(8'hc3, ack);
    `CHK("data nack", 1'b0, ack)
    rdchk("nack status", 5'h08, 8'hf8, 8'h88);
    wr(5'h04, 8'hc4);
    mst_u.put_byte(8'h11, ack);
    `CHK("not addressed", 1'b0, ack)
    rdchk("no flag", 5'h04, 8'h80, 8'h00);
    wr(5'h04, 8'he4);
    @(posedge clk_i);
    `CHK("start held", 1'b0, go)
    mst_u.stop_c();
    `CHK("start go", 1'b1, go)
    @(posedge clk_i);
    sleep_i <= 1'b1;
    mst_u.start_c();
    mst_u.put_byte(8'ha8, ack);
    `CHK("sleep ack", 1'b1, ack)
    `CHK("wake", 1'b1, wake_o)
    `CHK("sleep hold", 1'b1, scl_oe_o)
    wr(5'h04, 8'hc4);
    repeat (2) @(posedge clk_i);
    `CHK("wake cleared", 1'b0, wake_o)
    `CHK("sleep release", 1'b0, scl_oe_o)
    mst_u.put_byte(8'h5a, ack);
    `CHK("sleep data ack", 1'b1, ack)
    rdchk("sleep data kept", 5'h0c, 8'hff, 8'hc3);
    wr(5'h04, 8'hc4);
    sleep_i <= 1'b0;
    mst_u.stop_c();
    wr(5'h04, 8'hc4);
    `CHK("bus hangs", 0, mst_u.hangs)
    end_of_test();
  end
endmodule : test_two_wire_slave_receiver
`default_nettype wire
